// [hdl/spmd_pkg.sv]
// Shared constants and types for the serial port mode decoder.
// Assumes every user refers to names as spmd_pkg::name; nothing is imported.
package spmd_pkg;

  // Three mode-select pins and three line channels.
  localparam int MODE_W = 3;
  localparam int LINES = 3;

  // Mode-select codes that are not the balanced default.
  localparam logic [2:0] MODE_V35 = 3'h4;
  localparam logic [2:0] MODE_V28 = 3'h6;
  localparam logic [2:0] MODE_NO_CABLE = 3'h7;

  // Channel indices; driver 3 and receiver 1 share one cable pair.
  localparam int DRV_SHARED = 2;
  localparam int RCV_SHARED = 0;

  // Electrical standard carried on the active lines.
  typedef enum logic [1:0] {
    SPMD_STD_V11,
    SPMD_STD_V35,
    SPMD_STD_V28,
    SPMD_STD_OFF
  } spmd_std_type;

  // Complete line configuration produced by the decoder.
  typedef struct packed {
    logic [2:0] drv_en;
    logic [2:0] rcv_en;
    logic [2:0] diff_term;
    logic [2:0] cm_term;
    spmd_std_type std;
    logic pump_en;
    logic bias_en;
  } spmd_line_cfg_type;

  localparam spmd_line_cfg_type CFG_RESET = '{
    drv_en: 3'h0, rcv_en: 3'h0, diff_term: 3'h6, cm_term: 3'h0,
    std: SPMD_STD_OFF, pump_en: 1'b0, bias_en: 1'b0};

  // AXI4-Lite register map.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LINES = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Control register fields.
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_ROLE_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Status register fields.
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_ROLE_BIT = 3;
  localparam int STAT_STD_LSB = 4;
  localparam int STAT_NOCAB_BIT = 6;
  localparam int STAT_PUMP_BIT = 7;

  // Line register fields.
  localparam int LINE_DRV_LSB = 0;
  localparam int LINE_RCV_LSB = 3;
  localparam int LINE_DIFF_LSB = 6;
  localparam int LINE_CM_LSB = 9;

endpackage : spmd_pkg

// [hdl/spmd_decode.sv]
// Pure combinational decode of mode code and port role into a line setup.
// Assumes the mode code already has floating pins resolved to ones.
`timescale 1ns/10ps
module spmd_decode (
  mode_code, // Resolved three-bit mode code.
  role_dce, // High for the DCE role, low for DTE.
  cfg // Decoded line configuration.
);
  input wire logic [2:0] mode_code;
  input wire logic role_dce;
  output spmd_pkg::spmd_line_cfg_type cfg;

  // Standard selection, then per-line enables and terminations from it.
  always_comb begin
    cfg = spmd_pkg::CFG_RESET;
    unique case (mode_code)
      spmd_pkg::MODE_V35: cfg.std = spmd_pkg::SPMD_STD_V35;
      spmd_pkg::MODE_V28: cfg.std = spmd_pkg::SPMD_STD_V28;
      spmd_pkg::MODE_NO_CABLE: cfg.std = spmd_pkg::SPMD_STD_OFF;
      default: cfg.std = spmd_pkg::SPMD_STD_V11;
    endcase
    if (cfg.std != spmd_pkg::SPMD_STD_OFF) begin
      cfg.pump_en = 1'b1;
      cfg.bias_en = 1'b1;
      cfg.drv_en = 3'h7;
      cfg.rcv_en = 3'h7;
      cfg.drv_en[spmd_pkg::DRV_SHARED] = role_dce;
      cfg.rcv_en[spmd_pkg::RCV_SHARED] = !role_dce;
    end
    cfg.diff_term = cfg.rcv_en;
    // receivers 2 and 3 stay terminated
    cfg.diff_term[1] = 1'b1;
    cfg.diff_term[2] = 1'b1;
    if (cfg.std == spmd_pkg::SPMD_STD_V35) begin
      cfg.cm_term = cfg.rcv_en;
    end
  end

endmodule : spmd_decode

// [hdl/spmd_line_ctrl.sv]
// Registered line stage: gates driver pins and receiver outputs per channel.
// Assumes the enables come from the registered configuration in the top level.
`timescale 1ns/10ps
module spmd_line_ctrl (
  sys_clk, // System clock.
  resetn, // Asynchronous reset, active low.
  drv_en, // Driver enables per channel.
  rcv_en, // Receiver enables per channel.
  drv_data, // Logic data into the drivers.
  cable_rcv, // Sampled cable receiver levels.
  cable_drv, // Driver level toward the cable.
  cable_drv_oe, // High while the driver pair is driven.
  rcv_data, // Receiver data toward the logic side.
  rcv_oe // High while the receiver output is enabled.
);
  input wire logic sys_clk;
  input wire logic resetn;
  input wire logic [2:0] drv_en;
  input wire logic [2:0] rcv_en;
  input wire logic [2:0] drv_data;
  input wire logic [2:0] cable_rcv;
  output logic [2:0] cable_drv;
  output logic [2:0] cable_drv_oe;
  output logic [2:0] rcv_data;
  output logic [2:0] rcv_oe;

  logic [2:0] nxt_drv;
  logic [2:0] nxt_drv_oe;
  logic [2:0] nxt_rcv;
  logic [2:0] nxt_rcv_oe;

  // One identical gate per channel; disabled lines are held low.
  genvar g;
  for (g = 0; g < spmd_pkg::LINES; g++) begin : g_line
    always_comb begin
      nxt_drv_oe[g] = drv_en[g];
      nxt_drv[g] = drv_en[g] & drv_data[g];
      nxt_rcv_oe[g] = rcv_en[g];
      nxt_rcv[g] = rcv_en[g] & cable_rcv[g];
    end
  end

  // Registering keeps every pin glitch free at the cost of one cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cable_drv <= 3'h0;
      cable_drv_oe <= 3'h0;
      rcv_data <= 3'h0;
      rcv_oe <= 3'h0;
    end else begin
      cable_drv <= nxt_drv;
      cable_drv_oe <= nxt_drv_oe;
      rcv_data <= nxt_rcv;
      rcv_oe <= nxt_rcv_oe;
    end
  end

endmodule : spmd_line_ctrl

// [hdl/spmd_top.sv]
// Top of the serial port mode decoder: pin resolution, AXI4-Lite registers,
// registered line configuration and the per-channel line stage.
// Assumes pins are synchronous to sys_clk and a single AXI4-Lite master.
//
// How it works
// - codes 000-011 and 101 balanced, 100 V.35, 110 V.28, 111 no cable.
// - role high enables driver 3, low enables receiver 1 instead.
// - an undriven mode pin reads as one.
// - all mode pins floating gives no cable whatever the role.
// - in no cable every driver floats and every receiver is off.
// - in no cable receivers 2 and 3 keep differential termination.
// - balanced mode closes only the active receivers' differential switch.
// - termination follows the decoded standard with no other action.
// - V.35 closes differential and common-mode switches on active receivers.
// - no cable also turns off charge pump and bias.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module spmd_top (
  sys_clk, // System clock, 100 MHz.
  resetn, // Asynchronous reset, active low.
  proto_sel_bit0, // Mode-select pin 0 level.
  proto_sel_bit1, // Mode-select pin 1 level.
  proto_sel_bit2, // Mode-select pin 2 level.
  proto_sel_driven, // High where a mode pin is actually driven.
  port_role_sel, // High for DCE, low for DTE.
  line_driver_1, // Data into driver 1.
  line_driver_2, // Data into driver 2.
  line_driver_3, // Data into driver 3.
  cable_rcv, // Receiver levels from the cable.
  cable_drv, // Driver levels toward the cable.
  cable_drv_oe, // Driver pair output enables.
  line_receiver_1, // Receiver 1 data out.
  line_receiver_2, // Receiver 2 data out.
  line_receiver_3, // Receiver 3 data out.
  line_receiver_oe, // Receiver output enables.
  diff_term_switch, // Differential termination switches closed.
  common_mode_term_switch, // Common-mode termination switches closed.
  line_std, // Electrical standard in force.
  charge_pump_en, // Charge pump running.
  bias_en, // Bias circuitry running.
  s_axi_awaddr, // Write address.
  s_axi_awvalid, // Write address valid.
  s_axi_awready, // Write address ready.
  s_axi_wdata, // Write data.
  s_axi_wstrb, // Write byte strobes.
  s_axi_wvalid, // Write data valid.
  s_axi_wready, // Write data ready.
  s_axi_bresp, // Write response.
  s_axi_bvalid, // Write response valid.
  s_axi_bready, // Write response ready.
  s_axi_araddr, // Read address.
  s_axi_arvalid, // Read address valid.
  s_axi_arready, // Read address ready.
  s_axi_rdata, // Read data.
  s_axi_rresp, // Read response.
  s_axi_rvalid, // Read data valid.
  s_axi_rready // Read data ready.
);
  input wire logic sys_clk;
  input wire logic resetn;
  input wire logic proto_sel_bit0;
  input wire logic proto_sel_bit1;
  input wire logic proto_sel_bit2;
  input wire logic [2:0] proto_sel_driven;
  input wire logic port_role_sel;
  input wire logic line_driver_1;
  input wire logic line_driver_2;
  input wire logic line_driver_3;
  input wire logic [2:0] cable_rcv;
  output logic [2:0] cable_drv;
  output logic [2:0] cable_drv_oe;
  output logic line_receiver_1;
  output logic line_receiver_2;
  output logic line_receiver_3;
  output logic [2:0] line_receiver_oe;
  output logic [2:0] diff_term_switch;
  output logic [2:0] common_mode_term_switch;
  output spmd_pkg::spmd_std_type line_std;
  output logic charge_pump_en;
  output logic bias_en;
  input wire logic [3:0] s_axi_awaddr;
  input wire logic s_axi_awvalid;
  output logic s_axi_awready;
  input wire logic [31:0] s_axi_wdata;
  input wire logic [3:0] s_axi_wstrb;
  input wire logic s_axi_wvalid;
  output logic s_axi_wready;
  output logic [1:0] s_axi_bresp;
  output logic s_axi_bvalid;
  input wire logic s_axi_bready;
  input wire logic [3:0] s_axi_araddr;
  input wire logic s_axi_arvalid;
  output logic s_axi_arready;
  output logic [31:0] s_axi_rdata;
  output logic [1:0] s_axi_rresp;
  output logic s_axi_rvalid;
  input wire logic s_axi_rready;

  logic [2:0] pin_level;
  logic [2:0] pin_code;
  logic [2:0] eff_code;
  logic eff_role;
  spmd_pkg::spmd_line_cfg_type dec_cfg;
  spmd_pkg::spmd_line_cfg_type cfg_ff;
  logic [2:0] code_ff;
  logic role_ff;
  logic [4:0] ctrl_ff;
  logic [4:0] nxt_ctrl;
  logic aw_held_ff;
  logic nxt_aw_held;
  logic [3:0] awaddr_ff;
  logic [3:0] nxt_awaddr;
  logic w_held_ff;
  logic nxt_w_held;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic [3:0] wstrb_ff;
  logic [3:0] nxt_wstrb;
  logic nxt_awready;
  logic nxt_wready;
  logic nxt_bvalid;
  logic [1:0] nxt_bresp;
  logic nxt_arready;
  logic nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;
  logic [2:0] rcv_data;

  assign pin_level = {proto_sel_bit2, proto_sel_bit1, proto_sel_bit0};
  assign pin_code = pin_level | ~proto_sel_driven;

  // Software may override the pins; by default the pins, jumpers or cable
  // decide, so a board with no processor still works after reset.
  assign eff_code = ctrl_ff[spmd_pkg::CTRL_OVR_BIT] ?
      ctrl_ff[spmd_pkg::CTRL_MODE_LSB +: spmd_pkg::MODE_W] : pin_code;
  assign eff_role = ctrl_ff[spmd_pkg::CTRL_OVR_BIT] ?
      ctrl_ff[spmd_pkg::CTRL_ROLE_BIT] : port_role_sel;

  spmd_decode u_decode (
    .mode_code(eff_code),
    .role_dce(eff_role),
    .cfg(dec_cfg)
  );

  // Configuration is registered every cycle so that all outputs leave flops.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= spmd_pkg::CFG_RESET;
      code_ff <= spmd_pkg::MODE_NO_CABLE;
      role_ff <= 1'b0;
    end else begin
      cfg_ff <= dec_cfg;
      code_ff <= eff_code;
      role_ff <= eff_role;
    end
  end

  assign diff_term_switch = cfg_ff.diff_term;
  assign common_mode_term_switch = cfg_ff.cm_term;
  assign line_std = cfg_ff.std;
  assign charge_pump_en = cfg_ff.pump_en;
  assign bias_en = cfg_ff.bias_en;

  spmd_line_ctrl u_lines (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .drv_en(cfg_ff.drv_en),
    .rcv_en(cfg_ff.rcv_en),
    .drv_data({line_driver_3, line_driver_2, line_driver_1}),
    .cable_rcv(cable_rcv),
    .cable_drv(cable_drv),
    .cable_drv_oe(cable_drv_oe),
    .rcv_data(rcv_data),
    .rcv_oe(line_receiver_oe)
  );

  assign line_receiver_1 = rcv_data[0];
  assign line_receiver_2 = rcv_data[1];
  assign line_receiver_3 = rcv_data[2];

  // Write channel: address and data are caught separately in either order,
  // the register is written once both are held, then the response is given.
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_held = w_held_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_ctrl = ctrl_ff;
    nxt_bvalid = s_axi_bvalid;
    nxt_bresp = s_axi_bresp;
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (aw_held_ff && w_held_ff && !s_axi_bvalid) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = spmd_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        spmd_pkg::REG_CTRL: begin
          if (wstrb_ff[0]) begin
            nxt_ctrl = wdata_ff[4:0];
          end
        end
        spmd_pkg::REG_STATUS, spmd_pkg::REG_LINES: begin
          nxt_bresp = spmd_pkg::RESP_OKAY;
        end
        default: nxt_bresp = spmd_pkg::RESP_DECERR;
      endcase
    end
    // Ready drops while a word is held so a second one cannot overwrite it.
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready = !nxt_w_held && !nxt_bvalid;
  end

  // Write channel state.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      ctrl_ff <= spmd_pkg::CTRL_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff <= nxt_awaddr;
      w_held_ff <= nxt_w_held;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      ctrl_ff <= nxt_ctrl;
      s_axi_awready <= nxt_awready;
      s_axi_wready <= nxt_wready;
      s_axi_bvalid <= nxt_bvalid;
      s_axi_bresp <= nxt_bresp;
    end
  end

  // Read channel: data is sampled at the address handshake and held until
  // the master takes it; unmapped words read zero with a decode error.
  always_comb begin
    nxt_rvalid = s_axi_rvalid;
    nxt_rdata = s_axi_rdata;
    nxt_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = 32'h0;
      nxt_rresp = spmd_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        spmd_pkg::REG_CTRL: nxt_rdata[4:0] = ctrl_ff;
        spmd_pkg::REG_STATUS: begin
          nxt_rdata[spmd_pkg::STAT_MODE_LSB +: spmd_pkg::MODE_W] = code_ff;
          nxt_rdata[spmd_pkg::STAT_ROLE_BIT] = role_ff;
          nxt_rdata[spmd_pkg::STAT_STD_LSB +: 2] = cfg_ff.std;
          nxt_rdata[spmd_pkg::STAT_NOCAB_BIT] = (cfg_ff.std == spmd_pkg::SPMD_STD_OFF);
          nxt_rdata[spmd_pkg::STAT_PUMP_BIT] = cfg_ff.pump_en;
        end
        spmd_pkg::REG_LINES: begin
          nxt_rdata[spmd_pkg::LINE_DRV_LSB +: spmd_pkg::LINES] = cfg_ff.drv_en;
          nxt_rdata[spmd_pkg::LINE_RCV_LSB +: spmd_pkg::LINES] = cfg_ff.rcv_en;
          nxt_rdata[spmd_pkg::LINE_DIFF_LSB +: spmd_pkg::LINES] = cfg_ff.diff_term;
          nxt_rdata[spmd_pkg::LINE_CM_LSB +: spmd_pkg::LINES] = cfg_ff.cm_term;
        end
        default: nxt_rresp = spmd_pkg::RESP_DECERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  // Read channel state.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= nxt_arready;
      s_axi_rvalid <= nxt_rvalid;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rresp;
    end
  end

endmodule : spmd_top

// [tb/spmd_top_sva.sv]
// Concurrent checks on the ports of the mode decoder top level.
// Assumes the control override stays clear, so the mode pins decide.
`timescale 1ns/10ps
module spmd_top_sva (
  sys_clk, // Clock.
  resetn, // Reset, active low.
  proto_sel_bit0, // Mode pin 0.
  proto_sel_bit1, // Mode pin 1.
  proto_sel_bit2, // Mode pin 2.
  proto_sel_driven, // Pins driven.
  port_role_sel, // Role pin.
  cable_drv_oe, // Driver enables.
  line_receiver_oe, // Receiver enables.
  diff_term_switch, // Differential switches.
  common_mode_term_switch, // Common-mode switches.
  line_std, // Standard in force.
  charge_pump_en, // Pump on.
  bias_en // Bias on.
);
  input wire logic sys_clk;
  input wire logic resetn;
  input wire logic proto_sel_bit0;
  input wire logic proto_sel_bit1;
  input wire logic proto_sel_bit2;
  input wire logic [2:0] proto_sel_driven;
  input wire logic port_role_sel;
  input wire logic [2:0] cable_drv_oe;
  input wire logic [2:0] line_receiver_oe;
  input wire logic [2:0] diff_term_switch;
  input wire logic [2:0] common_mode_term_switch;
  input spmd_pkg::spmd_std_type line_std;
  input wire logic charge_pump_en;
  input wire logic bias_en;
  logic [2:0] code;
  spmd_pkg::spmd_std_type exp_std;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Floating pins read as one; literal codes keep this apart from the design.
  assign code = {proto_sel_bit2, proto_sel_bit1, proto_sel_bit0} | ~proto_sel_driven;
  always_comb begin
    exp_std = spmd_pkg::SPMD_STD_V11;
    if (code == 3'h4) exp_std = spmd_pkg::SPMD_STD_V35;
    if (code == 3'h6) exp_std = spmd_pkg::SPMD_STD_V28;
    if (code == 3'h7) exp_std = spmd_pkg::SPMD_STD_OFF;
  end
  property p_std;
    resetn |=> line_std == $past(exp_std);
  endproperty
  a_std: assert property (p_std)
    else $error("Standard does not follow the mode pins.");
  property p_role;
    exp_std != spmd_pkg::SPMD_STD_OFF |-> ##2
      cable_drv_oe == ($past(port_role_sel, 2) ? 3'h7 : 3'h3) &&
      line_receiver_oe == ($past(port_role_sel, 2) ? 3'h6 : 3'h7);
  endproperty
  a_role: assert property (p_role)
    else $error("Role does not pick driver 3 or receiver 1.");
  property p_off_lines;
    line_std == spmd_pkg::SPMD_STD_OFF |=> cable_drv_oe == 3'h0 && line_receiver_oe == 3'h0;
  endproperty
  a_off_lines: assert property (p_off_lines)
    else $error("A line stays enabled with no cable.");
  property p_off_term;
    line_std == spmd_pkg::SPMD_STD_OFF |-> diff_term_switch[2:1] == 2'h3;
  endproperty
  a_off_term: assert property (p_off_term)
    else $error("Receivers 2 and 3 lost termination with no cable.");
  property p_pump;
    charge_pump_en == (line_std != spmd_pkg::SPMD_STD_OFF) && bias_en == charge_pump_en;
  endproperty
  a_pump: assert property (p_pump)
    else $error("Pump or bias state does not match the standard.");
  property p_v11_term;
    line_std == spmd_pkg::SPMD_STD_V11 |-> common_mode_term_switch == 3'h0 &&
      diff_term_switch == {2'h3, !$past(port_role_sel)};
  endproperty
  a_v11_term: assert property (p_v11_term)
    else $error("Balanced mode termination is wrong.");
  property p_v35_term;
    line_std == spmd_pkg::SPMD_STD_V35 |-> common_mode_term_switch == diff_term_switch &&
      diff_term_switch[0] == !$past(port_role_sel);
  endproperty
  a_v35_term: assert property (p_v35_term)
    else $error("V.35 mode lacks the T termination.");
  property p_float;
    proto_sel_driven == 3'h3 && !proto_sel_bit1 && !proto_sel_bit0 |=>
      line_std == spmd_pkg::SPMD_STD_V35;
  endproperty
  a_float: assert property (p_float)
    else $error("A floating mode pin does not read as one.");
  property p_unplug;
    proto_sel_driven == 3'h0 |=> line_std == spmd_pkg::SPMD_STD_OFF ##1 cable_drv_oe == 3'h0;
  endproperty
  a_unplug: assert property (p_unplug)
    else $error("Pulled cable does not give the no-cable state.");
endmodule : spmd_top_sva
bind spmd_top spmd_top_sva i_spmd_top_sva (.sys_clk, .resetn, .proto_sel_bit0,
  .proto_sel_bit1, .proto_sel_bit2, .proto_sel_driven, .port_role_sel, .cable_drv_oe,
  .line_receiver_oe, .diff_term_switch, .common_mode_term_switch, .line_std,
  .charge_pump_en, .bias_en);

// [tb/spmd_cable_peer.sv]
// Remote port at the far end of the cable, driving our receive pairs.
// Assumes the bench picks what it sends, when it drives and if it lags.
`timescale 1ns/10ps
module spmd_cable_peer (
  sys_clk, // Clock.
  send_data, // Levels the remote port sends.
  send_en, // High while the remote port drives.
  slow, // High to answer one cycle late.
  cable_drv, // Our driver levels.
  cable_drv_oe, // Our driver enables.
  cable_rcv // Levels seen by our receivers.
);
  input wire logic sys_clk;
  input wire logic [2:0] send_data;
  input wire logic send_en;
  input wire logic slow;
  input wire logic [2:0] cable_drv;
  input wire logic [2:0] cable_drv_oe;
  output logic [2:0] cable_rcv;
  logic [2:0] late_ff;
  logic [2:0] idle_ff = 3'h5;
  // A released pair toggles, so a stale level can never pass as data.
  always_ff @(posedge sys_clk) begin
    late_ff <= send_data;
    idle_ff <= ~idle_ff;
  end
  // Pair one is shared: while our driver 3 drives it, that is the level seen.
  always_comb begin
    cable_rcv = send_en ? (slow ? late_ff : send_data) : idle_ff;
    if (cable_drv_oe[2]) cable_rcv[0] = cable_drv[2];
  end
endmodule : spmd_cable_peer

// [tb/spmd_top_tb.sv]
// Self-checking bench for the mode decoder top level.
// Assumes the cable peer and the bound checker are compiled alongside.
`timescale 1ns/10ps
module spmd_top_tb;
  typedef struct packed {
    logic [2:0] code;
    spmd_pkg::spmd_std_type std;
  } spmd_row_type;
  logic sys_clk, resetn, port_role_sel, proto_sel_bit0, proto_sel_bit1, proto_sel_bit2;
  logic line_driver_1, line_driver_2, line_driver_3, line_receiver_1, line_receiver_2;
  logic line_receiver_3, charge_pump_en, bias_en, peer_en, peer_slow;
  logic [2:0] proto_sel_driven, cable_rcv, cable_drv, cable_drv_oe, line_receiver_oe;
  logic [2:0] diff_term_switch, common_mode_term_switch, peer_data, eo, ro;
  spmd_pkg::spmd_std_type line_std;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_total, tests_run;
  spmd_row_type rows [8] = '{'{3'h0, spmd_pkg::SPMD_STD_V11}, '{3'h1, spmd_pkg::SPMD_STD_V11},
    '{3'h2, spmd_pkg::SPMD_STD_V11}, '{3'h3, spmd_pkg::SPMD_STD_V11},
    '{3'h4, spmd_pkg::SPMD_STD_V35}, '{3'h5, spmd_pkg::SPMD_STD_V11},
    '{3'h6, spmd_pkg::SPMD_STD_V28}, '{3'h7, spmd_pkg::SPMD_STD_OFF}};
  spmd_top i_spmd_top (.*);
  spmd_cable_peer i_spmd_cable_peer (.sys_clk, .send_data(peer_data), .send_en(peer_en),
    .slow(peer_slow), .cable_drv, .cable_drv_oe, .cable_rcv);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // Counts every comparison; case inequality keeps unknowns from matching.
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic hang();
    err_total++;
    $display("Error at %0t: handshake never completed", $time);
    print_verdict();
  endtask : hang
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Each channel is released at the edge where its ready is seen.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n == 50) hang();
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 50) hang();
  endtask : axi_read
  // Works out the line setup that a standard and role must give, then compares.
  task automatic cfg_check(input spmd_pkg::spmd_std_type s, input logic role, input string
    what, output logic [2:0] d, output logic [2:0] r);
    logic nc;
    nc = (s == spmd_pkg::SPMD_STD_OFF);
    d = nc ? 3'h0 : (role ? 3'h7 : 3'h3);
    r = nc ? 3'h0 : (role ? 3'h6 : 3'h7);
    check({cable_drv_oe, line_receiver_oe, diff_term_switch, common_mode_term_switch,
      charge_pump_en, bias_en, line_std},
      {d, r, r | 3'h6, (s == spmd_pkg::SPMD_STD_V35) ? r : 3'h0, !nc, !nc, s}, what);
  endtask : cfg_check
  // Main sequence: table rows first, then floating pins, timing, registers, reset.
  initial begin
    {resetn, port_role_sel, proto_sel_bit2, proto_sel_bit1, proto_sel_bit0} = 5'h00;
    {line_driver_3, line_driver_2, line_driver_1, peer_en, peer_slow} = 5'h00;
    {proto_sel_driven, peer_data, s_axi_awaddr, s_axi_araddr} = 14'h3800;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      {proto_sel_bit2, proto_sel_bit1, proto_sel_bit0} <= rows[i / 2].code;
      port_role_sel <= i[0];
      {line_driver_3, line_driver_2, line_driver_1} <= 3'(i + 3);
      peer_data <= 3'(i * 5);
      peer_en <= (rows[i / 2].std != spmd_pkg::SPMD_STD_OFF);
      peer_slow <= i[1];
      // Four edges: after a role swap our driver 3 still holds the shared pair for one edge.
      tick(4);
      cfg_check(rows[i / 2].std, i[0], "row", eo, ro);
      check({cable_drv, line_receiver_3, line_receiver_2, line_receiver_1},
        {{line_driver_3, line_driver_2, line_driver_1} & eo,
        ro & {peer_data[2:1], eo[2] ? line_driver_3 : peer_data[0]}}, "data");
      axi_read(spmd_pkg::REG_STATUS, rd, rsp);
      check({rsp, rd[7:0]}, {2'h0, eo != 3'h0, eo == 3'h0, rows[i / 2].std, i[0],
        rows[i / 2].code}, "status");
      $display("Row %0d done", i);
    end
    {proto_sel_bit2, proto_sel_bit1, proto_sel_bit0} <= 3'h0;
    proto_sel_driven <= 3'h0;
    port_role_sel <= 1'b1;
    tick(3);
    cfg_check(spmd_pkg::SPMD_STD_OFF, 1'b1, "unplugged", eo, ro);
    proto_sel_driven <= 3'h3;
    tick(3);
    cfg_check(spmd_pkg::SPMD_STD_V35, 1'b1, "one pin floating", eo, ro);
    proto_sel_driven <= 3'h7;
    {proto_sel_bit2, proto_sel_bit1, proto_sel_bit0} <= 3'h6;
    tick(2);
    check(line_std, spmd_pkg::SPMD_STD_V28, "one cycle update");
    $display("Floating pins and timing done");
    axi_write(spmd_pkg::REG_CTRL, 32'h0000_001A, rsp);
    axi_read(spmd_pkg::REG_CTRL, rd, rsp);
    check({rsp, rd}, {spmd_pkg::RESP_OKAY, 32'h0000_001A}, "control");
    axi_write(spmd_pkg::REG_STATUS, 32'h0000_00FF, rsp);
    check(rsp, spmd_pkg::RESP_OKAY, "read-only write");
    axi_read(spmd_pkg::REG_LINES, rd, rsp);
    check(rd[11:0], {3'h0, ro | 3'h6, ro, eo}, "lines");
    axi_write(4'hC, 32'h0000_0001, rsp);
    check(rsp, spmd_pkg::RESP_DECERR, "unmapped write");
    axi_read(4'hC, rd, rsp);
    check({rsp, rd}, {spmd_pkg::RESP_DECERR, 32'h0}, "unmapped read");
    $display("Registers done");
    resetn <= 1'b0;
    tick(1);
    cfg_check(spmd_pkg::SPMD_STD_OFF, 1'b0, "in reset", eo, ro);
    check({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h0, "readies in reset");
    resetn <= 1'b1;
    tick(3);
    cfg_check(spmd_pkg::SPMD_STD_V28, 1'b1, "after reset", eo, ro);
    $display("Mid-run reset done");
    print_verdict();
  end
endmodule : spmd_top_tb
